//--- hw/cpu_flow_control_decode.sv
// opcode decoder and stack sequencer for flow-control instructions
// Summary of operation
// - taken call pushes pc, sp minus two, 17 states
// - skipped call fetches target, 10 states
// - return pops pc, sp plus two, 10 states
// - conditional return: 11 taken, 5 skipped
// - interrupt return pops pc, 14 states
// - nmi return pops, restores live enable
// - restart pushes pc, jumps to 8t
// - absolute branch C2..FA, C3, E9
// - relative branches 20,28,30,38,18,10
// - F3, FB, 76, ED interrupt modes
// - DD/FD select index registers a/b
// - CB bit test 40 plus 8b plus r
// - alu bases 80,88,A0,B8 and immediates
`timescale 1ns/1ps
`include "flow_decode_regs.svh"
module cpu_flow_control_decode
   import flow_decode_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // instruction stream
   input  wire logic        i_op_valid,
   input  wire logic [7:0]  i_op_prefix,
   input  wire logic [7:0]  i_opcode,
   input  wire logic [15:0] i_target,
   // processor state
   input  wire logic [7:0]  i_flags,
   input  wire logic [15:0] i_pc_next,
   input  wire logic [15:0] i_pointer_pair,
   input  wire logic [7:0]  i_stack_lo,
   input  wire logic [7:0]  i_stack_hi,
   input  wire logic        i_nmi_entry,
   // results
   output logic             o_busy,
   output logic             o_done,
   output decode_s          o_decode,
   output logic             o_taken,
   output logic [15:0]      o_program_counter,
   output logic [15:0]      o_stack_pointer,
   output mem_wr_s          o_stack_wr,
   output logic [15:0]      o_stack_rd_addr,
   output logic [2:0]       o_m_cycles,
   output logic [4:0]       o_t_states,
   output logic [7:0]       o_flags,
   output logic             o_int_enable_flag_live,
   output logic             o_int_enable_flag_saved,
   output logic [1:0]       o_int_mode,
   output logic [1:0]       o_index_sel,
   output logic             o_halted
);

   typedef enum logic [2:0] {S_IDLE, S_PUSH_HI, S_PUSH_LO, S_POP_LO, S_POP_HI, S_WAIT} st_e;

   // condition evaluation against the flag byte
   function automatic logic cond_true(input logic [2:0] c, input logic [7:0] f);
      logic b;
      b = 1'b0;
      case (c[2:1])
         2'd0: b = f[`FLAG_Z];
         2'd1: b = f[`FLAG_C];
         2'd2: b = f[`FLAG_PV];
         default: b = f[`FLAG_S];
      endcase
      cond_true = c[0] ? b : ~b;
   endfunction

   // opcode classification
   function automatic decode_s decode_op(input logic [7:0] p, input logic [7:0] o);
      decode_s d;
      d = '0;
      d.cond = o[5:3];
      d.dst = o[5:3];
      d.src = o[2:0];
      d.bit_num = o[5:3];
      d.alu_sel = 2'd0;
      if (p == `OP_PFX_ED) begin
         if (o == `OP_ED_NMI_EXIT) d.kind = K_NMI_EXIT;
         else if (o == `OP_ED_INTERRUPT_EXIT) d.kind = K_INTERRUPT_EXIT;
         else if (o == `OP_ED_IM0) begin d.kind = K_IM; d.im_mode = 2'd0; end
         else if (o == `OP_ED_IM1) begin d.kind = K_IM; d.im_mode = 2'd1; end
         else if (o == `OP_ED_IM2) begin d.kind = K_IM; d.im_mode = 2'd2; end
      end else if (p == `OP_PFX_CB) begin
         if ({o[7:6], 6'h00} == `OP_BIT_BASE) d.kind = K_BIT;
      end else if (o == `OP_PFX_DD || o == `OP_PFX_FD) begin
         d.kind = K_PFX_IDX;
      end else if (o == `OP_CALL_U) d.kind = K_CALL;
      else if (o[7:6] == 2'b11 && o[2:0] == 3'b100) begin
         d.kind = K_CALL;
         d.conditional = 1'b1;
      end else if (o == `OP_RET_U) d.kind = K_RET;
      else if (o[7:6] == 2'b11 && o[2:0] == 3'b000) begin
         d.kind = K_RET;
         d.conditional = 1'b1;
      end else if (o[7:6] == 2'b11 && o[2:0] == 3'b111) d.kind = K_RST;
      else if (o == `OP_JP_U) d.kind = K_JP;
      else if (o == `OP_JP_PTR) d.kind = K_JP_PTR;
      else if (o[7:6] == 2'b11 && o[2:0] == 3'b010) begin
         d.kind = K_JP;
         d.conditional = 1'b1;
      end else if (o == `OP_JR_U) d.kind = K_JR;
      else if (o == `OP_DECREMENT_BRANCH_NONZERO) d.kind = K_DECREMENT_BRANCH_NONZERO;
      else if (o[7:5] == 3'b001 && o[2:0] == 3'b000) begin
         d.kind = K_JR;
         d.conditional = 1'b1;
         d.cond = {1'b0, o[4:3]};
      end else if (o == `OP_DI) d.kind = K_DI;
      else if (o == `OP_EI) d.kind = K_EI;
      else if (o == `OP_HALT) d.kind = K_HALT;
      else if (o[7:6] == 2'b01) d.kind = K_LOAD;
      else if ({o[7:3], 3'b000} == `OP_ADD_BASE || {o[7:3], 3'b000} == `OP_ADC_BASE ||
               {o[7:3], 3'b000} == `OP_AND_BASE || {o[7:3], 3'b000} == `OP_CMP_BASE) begin
         d.kind = K_ALU;
         d.alu_sel = ({o[7:3], 3'b000} == `OP_ADD_BASE) ? 2'd0 :
                     ({o[7:3], 3'b000} == `OP_ADC_BASE) ? 2'd1 :
                     ({o[7:3], 3'b000} == `OP_AND_BASE) ? 2'd2 : 2'd3;
      end else if (o == `OP_ADD_IMM || o == `OP_ADC_IMM ||
                   o == `OP_AND_IMM || o == `OP_CMP_IMM) begin
         d.kind = K_ALU_IMM;
         d.alu_sel = (o == `OP_ADD_IMM) ? 2'd0 : (o == `OP_ADC_IMM) ? 2'd1 :
                     (o == `OP_AND_IMM) ? 2'd2 : 2'd3;
      end
      decode_op = d;
   endfunction

   st_e         st_r, st_nxt;
   decode_s     dec_r, dec_nxt;
   logic        busy_r, busy_nxt, done_r, done_nxt, taken_r, taken_nxt;
   logic [15:0] pc_r, pc_nxt, sp_r, sp_nxt, ret_r, ret_nxt, tgt_r, tgt_nxt;
   logic [15:0] rd_r, rd_nxt;
   logic [7:0]  lo_r, lo_nxt;
   mem_wr_s     wr_r, wr_nxt;
   logic [2:0]  mc_r, mc_nxt;
   logic [4:0]  ts_r, ts_nxt;
   logic        ie1_r, ie1_nxt, ie2_r, ie2_nxt, halt_r, halt_nxt;
   logic [1:0]  im_r, im_nxt, idx_r, idx_nxt;
   logic [7:0]  flags_r;
   decode_s     d;
   logic        ok;

   // sequencer next state
   always_comb begin
      d = decode_op(i_op_prefix, i_opcode);
      ok = ~d.conditional | cond_true(d.cond, i_flags);
      st_nxt = st_r;
      dec_nxt = dec_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      taken_nxt = taken_r;
      pc_nxt = pc_r;
      sp_nxt = sp_r;
      ret_nxt = ret_r;
      tgt_nxt = tgt_r;
      rd_nxt = rd_r;
      lo_nxt = lo_r;
      wr_nxt = '0;
      mc_nxt = mc_r;
      ts_nxt = ts_r;
      ie1_nxt = ie1_r;
      ie2_nxt = ie2_r;
      im_nxt = im_r;
      idx_nxt = idx_r;
      halt_nxt = halt_r;
      if (i_nmi_entry) begin
         ie1_nxt = 1'b0; // saved copy keeps the pre-nmi enable
      end
      case (st_r)
         S_IDLE: begin
            if (i_op_valid) begin
               dec_nxt = d;
               taken_nxt = ok;
               ret_nxt = i_pc_next;
               tgt_nxt = i_target;
               busy_nxt = 1'b1;
               mc_nxt = 3'd1;
               ts_nxt = `T_DEFAULT;
               st_nxt = S_WAIT;
               idx_nxt = (i_op_prefix == `OP_PFX_DD) ? 2'd1 :
                         (i_op_prefix == `OP_PFX_FD) ? 2'd2 : 2'd0;
               case (d.kind)
                  K_CALL: begin
                     if (ok) begin
                        mc_nxt = 3'd5;
                        ts_nxt = `T_CALL_TAKEN;
                        st_nxt = S_PUSH_HI;
                     end else begin
                        mc_nxt = 3'd3;
                        ts_nxt = `T_CALL_SKIP;
                        pc_nxt = i_pc_next;
                     end
                  end
                  K_RST: begin
                     mc_nxt = 3'd3;
                     ts_nxt = `T_RST;
                     tgt_nxt = {10'h000, i_opcode[5:3], 3'b000};
                     st_nxt = S_PUSH_HI;
                  end
                  K_RET, K_INTERRUPT_EXIT, K_NMI_EXIT: begin
                     mc_nxt = (d.kind == K_RET) ? 3'd3 : 3'd4;
                     ts_nxt = (d.kind != K_RET) ? `T_INTERRUPT_EXIT :
                              d.conditional ? `T_RET_TAKEN : `T_RET_U;
                     if (ok) begin
                        rd_nxt = sp_r;
                        st_nxt = S_POP_LO;
                     end else begin
                        mc_nxt = 3'd1;
                        ts_nxt = `T_RET_SKIP;
                        pc_nxt = i_pc_next;
                     end
                  end
                  K_JP: pc_nxt = ok ? i_target : i_pc_next;
                  K_JP_PTR: pc_nxt = i_pointer_pair;
                  K_DI: begin
                     ie1_nxt = 1'b0;
                     ie2_nxt = 1'b0;
                     pc_nxt = i_pc_next;
                  end
                  K_EI: begin
                     ie1_nxt = 1'b1;
                     ie2_nxt = 1'b1;
                     pc_nxt = i_pc_next;
                  end
                  K_IM: begin
                     im_nxt = d.im_mode;
                     pc_nxt = i_pc_next;
                  end
                  K_HALT: begin
                     halt_nxt = 1'b1;
                     pc_nxt = i_pc_next;
                  end
                  default: pc_nxt = i_pc_next; // relative and data ops resolved outside
               endcase
            end
         end
         S_PUSH_HI: begin
            wr_nxt = '{we: 1'b1, addr: sp_r - 16'd1, data: ret_r[15:8]};
            st_nxt = S_PUSH_LO;
         end
         S_PUSH_LO: begin
            wr_nxt = '{we: 1'b1, addr: sp_r - 16'd2, data: ret_r[7:0]};
            sp_nxt = sp_r - 16'd2;
            pc_nxt = tgt_r;
            st_nxt = S_WAIT;
         end
         S_POP_LO: begin
            lo_nxt = i_stack_lo;
            rd_nxt = sp_r + 16'd1;
            st_nxt = S_POP_HI;
         end
         S_POP_HI: begin
            pc_nxt = {i_stack_hi, lo_r};
            sp_nxt = sp_r + 16'd2;
            if (dec_r.kind == K_NMI_EXIT) ie1_nxt = ie2_r;
            st_nxt = S_WAIT;
         end
         default: begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            st_nxt = S_IDLE;
         end
      endcase
   end

   // sequencer registers; flags are held unchanged by all flow ops
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st_r <= S_IDLE;
         dec_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         taken_r <= 1'b0;
         pc_r <= `PC_RESET;
         sp_r <= `SP_RESET;
         ret_r <= 16'h0000;
         tgt_r <= 16'h0000;
         rd_r <= 16'h0000;
         lo_r <= 8'h00;
         wr_r <= '0;
         mc_r <= 3'd0;
         ts_r <= 5'd0;
         ie1_r <= 1'b0;
         ie2_r <= 1'b0;
         im_r <= 2'd0;
         idx_r <= 2'd0;
         halt_r <= 1'b0;
         flags_r <= 8'h00;
      end else begin
         st_r <= st_nxt;
         dec_r <= dec_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         taken_r <= taken_nxt;
         pc_r <= pc_nxt;
         sp_r <= sp_nxt;
         ret_r <= ret_nxt;
         tgt_r <= tgt_nxt;
         rd_r <= rd_nxt;
         lo_r <= lo_nxt;
         wr_r <= wr_nxt;
         mc_r <= mc_nxt;
         ts_r <= ts_nxt;
         ie1_r <= ie1_nxt;
         ie2_r <= ie2_nxt;
         im_r <= im_nxt;
         idx_r <= idx_nxt;
         halt_r <= halt_nxt;
         flags_r <= i_flags;
      end
   end

   // outputs straight from registers
   assign o_busy = busy_r;
   assign o_done = done_r;
   assign o_decode = dec_r;
   assign o_taken = taken_r;
   assign o_program_counter = pc_r;
   assign o_stack_pointer = sp_r;
   assign o_stack_wr = wr_r;
   assign o_stack_rd_addr = rd_r;
   assign o_m_cycles = mc_r;
   assign o_t_states = ts_r;
   assign o_flags = flags_r;
   assign o_int_enable_flag_live = ie1_r;
   assign o_int_enable_flag_saved = ie2_r;
   assign o_int_mode = im_r;
   assign o_index_sel = idx_r;
   assign o_halted = halt_r;
endmodule

//--- hw/flow_decode_regs.svh
// constants for the flow-control decoder and sequencer
`ifndef FLOW_DECODE_REGS_SVH
`define FLOW_DECODE_REGS_SVH
`define OP_CALL_U     8'hCD
`define OP_RET_U      8'hC9
`define OP_JP_U       8'hC3
`define OP_JP_PTR     8'hE9
`define OP_JR_U       8'h18
`define OP_DECREMENT_BRANCH_NONZERO       8'h10
`define OP_DI         8'hF3
`define OP_EI         8'hFB
`define OP_HALT       8'h76
`define OP_PFX_ED     8'hED
`define OP_PFX_DD     8'hDD
`define OP_PFX_FD     8'hFD
`define OP_PFX_CB     8'hCB
`define OP_ED_NMI_EXIT    8'h45
`define OP_ED_INTERRUPT_EXIT    8'h4D
`define OP_ED_IM0     8'h46
`define OP_ED_IM1     8'h56
`define OP_ED_IM2     8'h5E
`define OP_ADD_BASE   8'h80
`define OP_ADC_BASE   8'h88
`define OP_AND_BASE   8'hA0
`define OP_CMP_BASE   8'hB8
`define OP_ADD_IMM    8'hC6
`define OP_ADC_IMM    8'hCE
`define OP_AND_IMM    8'hE6
`define OP_CMP_IMM    8'hFE
`define OP_BIT_BASE   8'h40
`define FLAG_S        7
`define FLAG_Z        6
`define FLAG_PV       2
`define FLAG_C        0
`define SP_RESET      16'hFFFF
`define PC_RESET      16'h0000
`define T_CALL_TAKEN  5'd17
`define T_CALL_SKIP   5'd10
`define T_RET_U       5'd10
`define T_RET_TAKEN   5'd11
`define T_RET_SKIP    5'd5
`define T_INTERRUPT_EXIT        5'd14
`define T_RST         5'd11
`define T_DEFAULT     5'd4
`endif

//--- hw/flow_decode_pkg.sv
// types for the flow-control decoder and sequencer
package flow_decode_pkg;
   typedef enum logic [4:0] {
      K_NONE, K_CALL, K_RET, K_INTERRUPT_EXIT, K_NMI_EXIT, K_RST, K_JP, K_JP_PTR, K_JR,
      K_DECREMENT_BRANCH_NONZERO, K_DI, K_EI, K_HALT, K_IM, K_ALU, K_ALU_IMM, K_LOAD, K_BIT,
      K_PFX_IDX
   } op_kind_e;
   typedef struct packed {
      op_kind_e   kind;
      logic       conditional;
      logic [2:0] cond;
      logic [2:0] dst;
      logic [2:0] src;
      logic [1:0] alu_sel;
      logic [1:0] im_mode;
      logic [2:0] bit_num;
   } decode_s;
   typedef struct packed {
      logic        we;
      logic [15:0] addr;
      logic [7:0]  data;
   } mem_wr_s;
endpackage

//--- test/flow_decode_properties.sv
// port assertions for the flow-control decoder and sequencer
`timescale 1ns/1ps
module flow_decode_checker
   import flow_decode_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // instruction stream and state
   input  wire logic        i_op_valid,
   input  wire logic [7:0]  i_op_prefix,
   input  wire logic [7:0]  i_opcode,
   input  wire logic [15:0] i_target,
   input  wire logic [7:0]  i_flags,
   input  wire logic [7:0]  i_stack_lo,
   input  wire logic [7:0]  i_stack_hi,
   // results
   input  wire logic        o_busy,
   input  wire logic        o_done,
   input  wire logic [15:0] o_program_counter,
   input  wire logic [15:0] o_stack_pointer,
   input  wire mem_wr_s     o_stack_wr,
   input  wire logic [15:0] o_stack_rd_addr,
   input  wire logic [2:0]  o_m_cycles,
   input  wire logic [4:0]  o_t_states,
   input  wire logic        o_int_enable_flag_live,
   input  wire logic        o_int_enable_flag_saved,
   input  wire logic        o_halted
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // accepted opcode without prefix, restart vector field
   wire logic       take_plain = i_op_valid && !o_busy && i_op_prefix == 8'h00;
   wire logic [2:0] rst_t      = i_opcode[5:3];
   // two byte stores, high then low
   sequence s_push;
      o_stack_wr.we && o_stack_wr.addr == o_stack_pointer - 16'h1
      ##1 o_stack_wr.we && o_stack_wr.addr == $past(o_stack_pointer) - 16'h2;
   endsequence
   // two byte reads, low then high
   sequence s_pop;
      o_stack_rd_addr == o_stack_pointer ##1 o_stack_rd_addr == o_stack_pointer + 16'h1;
   endsequence
   chk_call_push: assert property (take_plain && i_opcode == 8'hCD |=> ##1 s_push)
      else $error("call push order wrong");
   chk_call_target: assert property (take_plain && i_opcode == 8'hCD |->
      ##4 o_done && o_program_counter == $past(i_target, 4)) else $error("call target wrong");
   chk_call_time: assert property (take_plain && i_opcode == 8'hCD |=>
      o_m_cycles == 3'h5 && o_t_states == 5'h11) else $error("call timing wrong");
   chk_skip_call: assert property (take_plain && i_opcode == 8'hC4 && i_flags[6] |=>
      o_m_cycles == 3'h3 && o_t_states == 5'h0A && !o_stack_wr.we ##1 o_done && !o_stack_wr.we
      && $stable(o_stack_pointer)) else $error("skipped call touched stack");
   chk_ret_pop: assert property (take_plain && i_opcode == 8'hC9 |=> s_pop ##1
      o_program_counter == {$past(i_stack_hi), $past(i_stack_lo, 2)}
      && o_stack_pointer == $past(o_stack_pointer) + 16'h2) else $error("return pop wrong");
   chk_ret_time: assert property (take_plain && i_opcode == 8'hC9 |=>
      o_m_cycles == 3'h3 && o_t_states == 5'h0A) else $error("return timing wrong");
   chk_cret_skip: assert property (take_plain && i_opcode == 8'hC0 && i_flags[6] |=>
      o_t_states == 5'h05 ##1 o_done) else $error("skipped return timing wrong");
   chk_rst_vector: assert property (take_plain && i_opcode[7:6] == 2'h3
      && i_opcode[2:0] == 3'h7 |-> ##4 o_done
      && o_program_counter == {10'h000, $past(rst_t, 4), 3'h0}) else $error("restart vector wrong");
   chk_nmi_exit_enable: assert property (i_op_valid && !o_busy && i_op_prefix == 8'hED
      && i_opcode == 8'h45 |-> ##4 o_done && o_int_enable_flag_live == o_int_enable_flag_saved)
      else $error("nmi return enable wrong");
   chk_halt_set: assert property (take_plain && i_opcode == 8'h76 |-> ##2 o_halted)
      else $error("halt not set");
   chk_rst_time: assert property (take_plain && i_opcode[7:6] == 2'h3
      && i_opcode[2:0] == 3'h7 |=> o_m_cycles == 3'h3 && o_t_states == 5'h0B)
      else $error("restart timing wrong");
   chk_interrupt_exit_time: assert property (i_op_valid && !o_busy && i_op_prefix == 8'hED
      && i_opcode == 8'h4D |=> o_m_cycles == 3'h4 && o_t_states == 5'h0E)
      else $error("interrupt return timing wrong");
endmodule
bind cpu_flow_control_decode flow_decode_checker chk (.i_clk(i_clk), .i_resetn(i_resetn),
   .i_op_valid(i_op_valid), .i_op_prefix(i_op_prefix), .i_opcode(i_opcode),
   .i_target(i_target), .i_flags(i_flags), .i_stack_lo(i_stack_lo), .i_stack_hi(i_stack_hi),
   .o_busy(o_busy), .o_done(o_done), .o_program_counter(o_program_counter),
   .o_stack_pointer(o_stack_pointer), .o_stack_wr(o_stack_wr),
   .o_stack_rd_addr(o_stack_rd_addr), .o_m_cycles(o_m_cycles), .o_t_states(o_t_states),
   .o_int_enable_flag_live(o_int_enable_flag_live),
   .o_int_enable_flag_saved(o_int_enable_flag_saved), .o_halted(o_halted));

//--- test/stack_mem_model.sv
// stack memory model answering the sequencer's reads and writes
`timescale 1ns/1ps
module stack_mem_model
   import flow_decode_pkg::*;
(
   // clock
   input  wire logic        i_clk,
   // sequencer side
   input  wire mem_wr_s     i_wr,
   input  wire logic [15:0] i_rd_addr,
   output logic [7:0]       o_rd_data
);
   logic [7:0] mem [0:65535];
   // byte stores from pushes
   always @(posedge i_clk) begin
      if (i_wr.we === 1'b1) begin
         mem[i_wr.addr] <= i_wr.data;
      end
   end
   // zero-wait read of the addressed byte
   assign o_rd_data = mem[i_rd_addr];
endmodule

//--- test/testbench.sv
// self-checking bench for the flow-control decoder and sequencer
`timescale 1ns/1ps
module testbench;
   import flow_decode_pkg::*;
   typedef struct {op_kind_e kind; logic [15:0] pc; logic [15:0] sp;} exp_s;
   logic        i_clk, i_resetn, i_op_valid, i_nmi_entry, tk;
   logic [7:0]  i_op_prefix, i_opcode, i_flags, rd_data, fl, o_flags;
   logic [15:0] i_target, i_pc_next, i_pointer_pair, tgt, pcn, ra, sp_m;
   logic        o_busy, o_done, o_live, o_saved, o_halted, o_taken;
   logic [15:0] o_pc, o_sp, o_rd_addr;
   logic [1:0]  o_index_sel, o_int_mode;
   logic [31:0] lfsr;
   decode_s     o_decode;
   mem_wr_s     o_wr;
   exp_s        q [$];
   exp_s        e;
   int          n_fail, check_count, cyc;
   logic [15:0] tab [27] = '{16'h00C3, 16'h00E9, 16'h0020, 16'h0028, 16'h0030, 16'h0038,
      16'h0018, 16'h0010, 16'h00F3, 16'h00FB, 16'hED46, 16'hED56, 16'hED5E, 16'h0080,
      16'h0088, 16'h00A0, 16'h00BF, 16'h00C6, 16'h00CE, 16'h00E6, 16'h00FE, 16'h0041,
      16'h0047, 16'hCB40, 16'hCB7F, 16'h00DD, 16'hDD80};
   op_kind_e    kt [27] = '{K_JP, K_JP_PTR, K_JR, K_JR, K_JR, K_JR, K_JR, K_DECREMENT_BRANCH_NONZERO, K_DI,
      K_EI, K_IM, K_IM, K_IM, K_ALU, K_ALU, K_ALU, K_ALU, K_ALU_IMM, K_ALU_IMM, K_ALU_IMM,
      K_ALU_IMM, K_LOAD, K_LOAD, K_BIT, K_BIT, K_PFX_IDX, K_ALU};
   cpu_flow_control_decode dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_op_valid(i_op_valid),
      .i_op_prefix(i_op_prefix), .i_opcode(i_opcode), .i_target(i_target), .i_flags(i_flags),
      .i_pc_next(i_pc_next), .i_pointer_pair(i_pointer_pair), .i_stack_lo(rd_data),
      .i_stack_hi(rd_data), .i_nmi_entry(i_nmi_entry), .o_busy(o_busy), .o_done(o_done),
      .o_decode(o_decode), .o_taken(o_taken), .o_program_counter(o_pc), .o_stack_pointer(o_sp),
      .o_stack_wr(o_wr), .o_stack_rd_addr(o_rd_addr), .o_m_cycles(), .o_t_states(),
      .o_flags(o_flags), .o_int_enable_flag_live(o_live), .o_int_enable_flag_saved(o_saved),
      .o_int_mode(o_int_mode), .o_index_sel(o_index_sel), .o_halted(o_halted));
   stack_mem_model mem (.i_clk(i_clk), .i_wr(o_wr), .i_rd_addr(o_rd_addr), .o_rd_data(rd_data));
   // clock
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[15:0];
   endfunction
   // condition field against the flag byte
   function automatic logic cond_ok(input logic [2:0] c, input logic [7:0] f);
      logic [3:0] sel;
      sel = {f[7], f[2], f[0], f[6]};
      return sel[c[2:1]] == c[0];
   endfunction
   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (q.size() != 0) n_fail++;
      $display("checks %0d errors %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic newr();
      fl = 8'(rnd());
      tgt = rnd();
      pcn = rnd();
   endtask
   // one instruction: drive, note expectation, wait for completion
   task automatic run(input logic [7:0] pf, input logic [7:0] op, input op_kind_e k,
                      input logic [15:0] pc, input logic [15:0] sp);
      @(posedge i_clk);
      i_op_prefix <= pf;
      i_opcode <= op;
      i_target <= tgt;
      i_pc_next <= pcn;
      i_flags <= fl;
      i_op_valid <= 1'b1;
      q.push_back('{k, pc, sp});
      @(posedge i_clk);
      i_op_valid <= 1'b0;
      repeat (20) begin
         @(negedge i_clk);
         if (o_done === 1'b1) break;
      end
      check16(o_flags, fl);
      sp_m = sp;
   endtask
   // completion monitor
   always @(negedge i_clk) begin
      if (i_resetn && o_done === 1'b1) begin
         if (q.size() == 0) begin
            n_fail++;
            $display("Error at %0t: completion with nothing expected", $time);
         end else begin
            e = q.pop_front();
            check16(o_decode.kind, e.kind);
            check16(o_pc, e.pc);
            check16(o_sp, e.sp);
         end
      end
   end
   // hang guard
   always @(posedge i_clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      {i_resetn, i_op_valid, i_nmi_entry, i_op_prefix, i_opcode, i_flags} = '0;
      {i_target, i_pc_next, n_fail, check_count, cyc} = '0;
      lfsr = 32'h6AC8;
      sp_m = 16'hFFFF;
      i_pointer_pair = rnd();
      repeat (12) @(posedge i_clk);
      i_resetn <= 1'b1;
      foreach (tab[i]) begin
         newr();
         run(tab[i][15:8], tab[i][7:0], kt[i], tab[i] == 16'h00C3 ? tgt :
             (tab[i] == 16'h00E9 ? i_pointer_pair : pcn), sp_m);
         if (tab[i][15:8] == 8'hED) check16(o_int_mode, tab[i][7:0] == 8'h46 ? 16'h0 :
            (tab[i][7:0] == 8'h56 ? 16'h1 : 16'h2));
      end
      newr();
      run(8'hFD, 8'h80, K_ALU, pcn, sp_m);
      check16(o_index_sel, 16'h2);
      for (int c = 0; c < 8; c++) begin
         newr();
         ra = pcn;
         run(8'h00, 8'hCD, K_CALL, tgt, sp_m - 16'h2);
         newr();
         tk = cond_ok(c[2:0], fl);
         run(8'h00, {2'h3, c[2:0], 3'h0}, K_RET, tk ? ra : pcn, tk ? sp_m + 16'h2 : sp_m);
         check16(o_taken, tk);
         if (!tk) run(8'h00, 8'hC9, K_RET, ra, sp_m + 16'h2);
         newr();
         tk = cond_ok(c[2:0], fl);
         ra = pcn;
         run(8'h00, {2'h3, c[2:0], 3'h4}, K_CALL, tk ? tgt : pcn, tk ? sp_m - 16'h2 : sp_m);
         check16(o_taken, tk);
         if (tk) run(8'h00, 8'hC9, K_RET, ra, sp_m + 16'h2);
      end
      // directed skips: zero flag set makes the nz forms fall through
      newr();
      fl[6] = 1'b1;
      run(8'h00, 8'hC4, K_CALL, pcn, sp_m);
      run(8'h00, 8'hC0, K_RET, pcn, sp_m);
      for (int t = 0; t < 8; t++) begin
         newr();
         ra = pcn;
         run(8'h00, {2'h3, t[2:0], 3'h7}, K_RST, {10'h000, t[2:0], 3'h0}, sp_m - 16'h2);
         run(8'h00, 8'hC9, K_RET, ra, sp_m + 16'h2);
      end
      newr();
      ra = pcn;
      run(8'h00, 8'hCD, K_CALL, tgt, sp_m - 16'h2);
      run(8'hED, 8'h4D, K_INTERRUPT_EXIT, ra, sp_m + 16'h2);
      @(posedge i_clk);
      i_nmi_entry <= 1'b1;
      @(posedge i_clk);
      i_nmi_entry <= 1'b0;
      @(negedge i_clk);
      check16(o_live, 16'h0);
      ra = pcn;
      run(8'h00, 8'hCD, K_CALL, tgt, sp_m - 16'h2);
      run(8'hED, 8'h45, K_NMI_EXIT, ra, sp_m + 16'h2);
      check16({o_live, o_saved}, 16'h3);
      run(8'h00, 8'h76, K_HALT, pcn, sp_m);
      check16(o_halted, 16'h1);
      // let the completion monitor take the last note first
      @(posedge i_clk);
      summarize();
   end
endmodule
